// file: design/mmpp_consts.svh
// Address map, field layout, widths and reset values of the parallel ports.
// Assumes one 32-bit APB address space and word-aligned accesses.
`ifndef MMPP_CONSTS_SVH
`define MMPP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Port base addresses
// ----------------------------------------------------------------------------
`define MMPP_LIGHTS_BASE  32'hFF20_0000
`define MMPP_DISP_LO_BASE 32'hFF20_0020
`define MMPP_DISP_HI_BASE 32'hFF20_0030
`define MMPP_SWITCH_BASE  32'hFF20_0040
`define MMPP_BTN_BASE     32'hFF20_0050
`define MMPP_EXA_BASE     32'hFF20_0060
`define MMPP_EXB_BASE     32'hFF20_0070

// ----------------------------------------------------------------------------
// Register offsets within a port
// ----------------------------------------------------------------------------
`define MMPP_DATA_OFS 32'h0000_0000
`define MMPP_DIR_OFS  32'h0000_0004
`define MMPP_AUX8_OFS 32'h0000_0008
`define MMPP_AUXC_OFS 32'h0000_000C

// ----------------------------------------------------------------------------
// Widths and display field layout
// ----------------------------------------------------------------------------
`define MMPP_LIGHTS_W 10
`define MMPP_SWITCH_W 10
`define MMPP_BTN_W    4
`define MMPP_DISP_W   32
`define MMPP_EXP_W    32
`define MMPP_SEG_W    7
`define MMPP_DIGIT_W  8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MMPP_RESET_WORD 32'h0000_0000
`define MMPP_RESET_BIT  1'h0

`endif

// file: design/mmpp_pkg.sv
// Types shared by the parallel port block.
// Assumes the constants header is compiled alongside.
package mmpp_pkg;

    typedef logic [31:0] mmpp_word_t;

    typedef enum logic [3:0] {
        REG_NONE,
        REG_LIGHTS,
        REG_DISP_LO,
        REG_DISP_HI,
        REG_SWITCH,
        REG_BTN_DATA,
        REG_BTN_AUX8,
        REG_BTN_AUXC,
        REG_EXA_DATA,
        REG_EXA_DIR,
        REG_EXA_AUX8,
        REG_EXA_AUXC,
        REG_EXB_DATA,
        REG_EXB_DIR,
        REG_EXB_AUX8,
        REG_EXB_AUXC
    } mmpp_reg_e;

endpackage

// file: design/mmpp_ports.sv
// Memory-mapped parallel ports: lights, two display ports, switches,
// pushbuttons and two bidirectional expansion headers behind one APB slave.
// Assumes a single clock, synchronous active-low reset, word accesses only.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "mmpp_consts.svh"

module mmpp_ports
    import mmpp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic       [9:0] redLights,
    output logic       [6:0] displayDigit0,
    output logic       [6:0] displayDigit1,
    output logic       [6:0] displayDigit2,
    output logic       [6:0] displayDigit3,
    output logic       [6:0] displayDigit4,
    output logic       [6:0] displayDigit5,
    input  wire logic  [9:0] slideSwitches,
    input  wire logic  [3:0] pushbuttons,
    input  wire logic [31:0] expansionHeaderAIn,
    output logic      [31:0] expansionHeaderAOut,
    output logic      [31:0] expansionHeaderAOe,
    input  wire logic [31:0] expansionHeaderBIn,
    output logic      [31:0] expansionHeaderBOut,
    output logic      [31:0] expansionHeaderBOe
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Maps a byte address onto a register; anything else is unmapped.
    function automatic mmpp_reg_e decodeAddr(input logic [31:0] addr);
        mmpp_reg_e sel;
        sel = REG_NONE;
        case (addr)
            `MMPP_LIGHTS_BASE  + `MMPP_DATA_OFS: sel = REG_LIGHTS;
            `MMPP_DISP_LO_BASE + `MMPP_DATA_OFS: sel = REG_DISP_LO;
            `MMPP_DISP_HI_BASE + `MMPP_DATA_OFS: sel = REG_DISP_HI;
            `MMPP_SWITCH_BASE  + `MMPP_DATA_OFS: sel = REG_SWITCH;
            `MMPP_BTN_BASE     + `MMPP_DATA_OFS: sel = REG_BTN_DATA;
            `MMPP_BTN_BASE     + `MMPP_AUX8_OFS: sel = REG_BTN_AUX8;
            `MMPP_BTN_BASE     + `MMPP_AUXC_OFS: sel = REG_BTN_AUXC;
            `MMPP_EXA_BASE     + `MMPP_DATA_OFS: sel = REG_EXA_DATA;
            `MMPP_EXA_BASE     + `MMPP_DIR_OFS:  sel = REG_EXA_DIR;
            `MMPP_EXA_BASE     + `MMPP_AUX8_OFS: sel = REG_EXA_AUX8;
            `MMPP_EXA_BASE     + `MMPP_AUXC_OFS: sel = REG_EXA_AUXC;
            `MMPP_EXB_BASE     + `MMPP_DATA_OFS: sel = REG_EXB_DATA;
            `MMPP_EXB_BASE     + `MMPP_DIR_OFS:  sel = REG_EXB_DIR;
            `MMPP_EXB_BASE     + `MMPP_AUX8_OFS: sel = REG_EXB_AUX8;
            `MMPP_EXB_BASE     + `MMPP_AUXC_OFS: sel = REG_EXB_AUXC;
            default:                             sel = REG_NONE;
        endcase
        return sel;
    endfunction

    // Pin value seen by software: stored value on outputs, pin level on inputs.
    function automatic logic [31:0] mergePins(
        input logic [31:0] dir,
        input logic [31:0] dout,
        input logic [31:0] din
    );
        return (dir & dout) | (~dir & din);
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [`MMPP_LIGHTS_W-1:0] lightsQ;
    logic  [`MMPP_DISP_W-1:0]  dispLoQ;
    logic  [`MMPP_DISP_W-1:0]  dispHiQ;
    logic   [`MMPP_BTN_W-1:0]  btnAux8Q;
    logic   [`MMPP_BTN_W-1:0]  btnAuxCQ;
    logic   [`MMPP_EXP_W-1:0]  exaDataQ;
    logic   [`MMPP_EXP_W-1:0]  exaDirQ;
    logic   [`MMPP_EXP_W-1:0]  exaAux8Q;
    logic   [`MMPP_EXP_W-1:0]  exaAuxCQ;
    logic   [`MMPP_EXP_W-1:0]  exbDataQ;
    logic   [`MMPP_EXP_W-1:0]  exbDirQ;
    logic   [`MMPP_EXP_W-1:0]  exbAux8Q;
    logic   [`MMPP_EXP_W-1:0]  exbAuxCQ;
    logic [`MMPP_SWITCH_W-1:0] swMetaQ;
    logic [`MMPP_SWITCH_W-1:0] swSyncQ;
    logic   [`MMPP_BTN_W-1:0]  btnMetaQ;
    logic   [`MMPP_BTN_W-1:0]  btnSyncQ;
    logic   [`MMPP_EXP_W-1:0]  exaMetaQ;
    logic   [`MMPP_EXP_W-1:0]  exaSyncQ;
    logic   [`MMPP_EXP_W-1:0]  exbMetaQ;
    logic   [`MMPP_EXP_W-1:0]  exbSyncQ;
    mmpp_word_t                prdataQ;
    mmpp_word_t                readD;
    logic                      slverrQ;
    mmpp_reg_e                 sel;
    logic                      setupPhase;
    logic                      writeStrobe;

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    assign sel         = decodeAddr(paddr);
    assign setupPhase  = psel & ~penable;
    // Every access phase completes at once, so it is also the write edge.
    assign writeStrobe = psel & penable & pwrite;

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            swMetaQ <= '0;
            swSyncQ <= '0;
        end else begin
            swMetaQ <= slideSwitches;
            swSyncQ <= swMetaQ;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            btnMetaQ <= '0;
            btnSyncQ <= '0;
        end else begin
            btnMetaQ <= pushbuttons;
            btnSyncQ <= btnMetaQ;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exaMetaQ <= '0;
            exaSyncQ <= '0;
        end else begin
            exaMetaQ <= expansionHeaderAIn;
            exaSyncQ <= exaMetaQ;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exbMetaQ <= '0;
            exbSyncQ <= '0;
        end else begin
            exbMetaQ <= expansionHeaderBIn;
            exbSyncQ <= exbMetaQ;
        end
    end

    // ------------------------------------------------------------------------
    // Output ports: lights and displays
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lightsQ <= '0;
        end else if (writeStrobe && sel == REG_LIGHTS) begin
            lightsQ <= pwdata[`MMPP_LIGHTS_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dispLoQ <= `MMPP_RESET_WORD;
        end else if (writeStrobe && sel == REG_DISP_LO) begin
            dispLoQ <= pwdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dispHiQ <= `MMPP_RESET_WORD;
        end else if (writeStrobe && sel == REG_DISP_HI) begin
            dispHiQ <= pwdata;
        end
    end

    // ------------------------------------------------------------------------
    // Pushbutton extra registers
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            btnAux8Q <= '0;
            btnAuxCQ <= '0;
        end else if (writeStrobe) begin
            if (sel == REG_BTN_AUX8) begin
                btnAux8Q <= pwdata[`MMPP_BTN_W-1:0];
            end
            if (sel == REG_BTN_AUXC) begin
                btnAuxCQ <= pwdata[`MMPP_BTN_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Expansion port A
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exaDataQ <= `MMPP_RESET_WORD;
        end else if (writeStrobe && sel == REG_EXA_DATA) begin
            exaDataQ <= pwdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exaDirQ <= `MMPP_RESET_WORD;
        end else if (writeStrobe && sel == REG_EXA_DIR) begin
            exaDirQ <= pwdata;
        end
    end

    // The extra words are plain storage and do not touch the pins.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exaAux8Q <= `MMPP_RESET_WORD;
            exaAuxCQ <= `MMPP_RESET_WORD;
        end else if (writeStrobe) begin
            if (sel == REG_EXA_AUX8) begin
                exaAux8Q <= pwdata;
            end
            if (sel == REG_EXA_AUXC) begin
                exaAuxCQ <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Expansion port B
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exbDataQ <= `MMPP_RESET_WORD;
        end else if (writeStrobe && sel == REG_EXB_DATA) begin
            exbDataQ <= pwdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exbDirQ <= `MMPP_RESET_WORD;
        end else if (writeStrobe && sel == REG_EXB_DIR) begin
            exbDirQ <= pwdata;
        end
    end

    // The extra words are plain storage and do not touch the pins.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exbAux8Q <= `MMPP_RESET_WORD;
            exbAuxCQ <= `MMPP_RESET_WORD;
        end else if (writeStrobe) begin
            if (sel == REG_EXB_AUX8) begin
                exbAux8Q <= pwdata;
            end
            if (sel == REG_EXB_AUXC) begin
                exbAuxCQ <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always_comb begin
        readD = `MMPP_RESET_WORD;
        unique case (sel)
            REG_NONE:     readD = `MMPP_RESET_WORD;
            REG_LIGHTS:   readD = mmpp_word_t'(lightsQ);
            REG_DISP_LO:  readD = dispLoQ;
            REG_DISP_HI:  readD = dispHiQ;
            REG_SWITCH:   readD = mmpp_word_t'(swSyncQ);
            REG_BTN_DATA: readD = mmpp_word_t'(btnSyncQ);
            REG_BTN_AUX8: readD = mmpp_word_t'(btnAux8Q);
            REG_BTN_AUXC: readD = mmpp_word_t'(btnAuxCQ);
            REG_EXA_DATA: readD = mergePins(exaDirQ, exaDataQ, exaSyncQ);
            REG_EXA_DIR:  readD = exaDirQ;
            REG_EXA_AUX8: readD = exaAux8Q;
            REG_EXA_AUXC: readD = exaAuxCQ;
            REG_EXB_DATA: readD = mergePins(exbDirQ, exbDataQ, exbSyncQ);
            REG_EXB_DIR:  readD = exbDirQ;
            REG_EXB_AUX8: readD = exbAux8Q;
            REG_EXB_AUXC: readD = exbAuxCQ;
        endcase
    end

    // Read data and error are captured in the setup cycle, so the access
    // phase answers from flip-flops with no wait state.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            prdataQ <= `MMPP_RESET_WORD;
            slverrQ <= `MMPP_RESET_BIT;
        end else if (setupPhase) begin
            prdataQ <= pwrite ? `MMPP_RESET_WORD : readD;
            slverrQ <= (sel == REG_NONE);
        end
    end

    assign prdata  = prdataQ;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & slverrQ;

    // ------------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------------
    assign redLights = lightsQ;

    // Raw segment bits, one byte per digit, lowest digit lowest.
    assign displayDigit0 = dispLoQ[0*`MMPP_DIGIT_W +: `MMPP_SEG_W];
    assign displayDigit1 = dispLoQ[1*`MMPP_DIGIT_W +: `MMPP_SEG_W];
    assign displayDigit2 = dispLoQ[2*`MMPP_DIGIT_W +: `MMPP_SEG_W];
    assign displayDigit3 = dispLoQ[3*`MMPP_DIGIT_W +: `MMPP_SEG_W];
    assign displayDigit4 = dispHiQ[0*`MMPP_DIGIT_W +: `MMPP_SEG_W];
    assign displayDigit5 = dispHiQ[1*`MMPP_DIGIT_W +: `MMPP_SEG_W];

    assign expansionHeaderAOut = exaDataQ;
    assign expansionHeaderAOe  = exaDirQ;
    assign expansionHeaderBOut = exbDataQ;
    assign expansionHeaderBOe  = exbDirQ;

endmodule

// file: testbench/memory_mapped_parallel_ports_tb_top.sv
// Self-checking bench for the parallel port block over APB.
// Assumes the board model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "mmpp_consts.svh"
module memory_mapped_parallel_ports_tb_top;
    logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd, b, pad, padA, padB;
    logic [31:0] aOut, aOe, bOut, bOe, pinA, pinB;
    logic  [9:0] redLights, slideSwitches, swLevel;
    logic  [6:0] dig0, dig1, dig2, dig3, dig4, dig5;
    logic  [3:0] pushbuttons, btnLevel;
    int          n_errors, n_tests, cyc;

    mmpp_ports u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .redLights(redLights), .displayDigit0(dig0),
        .displayDigit1(dig1), .displayDigit2(dig2), .displayDigit3(dig3),
        .displayDigit4(dig4), .displayDigit5(dig5), .slideSwitches(slideSwitches),
        .pushbuttons(pushbuttons), .expansionHeaderAIn(pinA), .expansionHeaderAOut(aOut),
        .expansionHeaderAOe(aOe), .expansionHeaderBIn(pinB), .expansionHeaderBOut(bOut),
        .expansionHeaderBOe(bOe));
    mmpp_board_model u_board (.swLevel(swLevel), .btnLevel(btnLevel), .padA(padA),
        .padB(padB), .outA(aOut), .oeA(aOe), .outB(bOut), .oeB(bOe),
        .slideSwitches(slideSwitches), .pushbuttons(pushbuttons), .pinA(pinA), .pinB(pinB));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, e});
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {swLevel, btnLevel, padA, padB} = '0;
        {n_errors, n_tests, cyc} = '0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        rchk(`MMPP_LIGHTS_BASE, 32'h0, 1'b0);
        rchk(`MMPP_DISP_HI_BASE, 32'h0, 1'b0);
        rchk(`MMPP_EXB_BASE + 32'h4, 32'h0, 1'b0);
        done("reset");
        apb(1'b1, `MMPP_LIGHTS_BASE, 32'hFFFF_FD55);
        @(negedge ref_clk);
        chk({22'h0, redLights}, 32'h155);
        rchk(`MMPP_LIGHTS_BASE, 32'h155, 1'b0);
        apb(1'b1, `MMPP_DISP_LO_BASE, 32'h8765_4321);
        @(negedge ref_clk);
        chk({4'h0, dig3, dig2, dig1, dig0}, {4'h0, 7'h07, 7'h65, 7'h43, 7'h21});
        rchk(`MMPP_DISP_LO_BASE, 32'h8765_4321, 1'b0);
        apb(1'b1, `MMPP_DISP_HI_BASE, 32'hA5A5_5B3C);
        @(negedge ref_clk);
        chk({18'h0, dig5, dig4}, {18'h0, 7'h5B, 7'h3C});
        rchk(`MMPP_DISP_HI_BASE, 32'hA5A5_5B3C, 1'b0);
        apb(1'b1, `MMPP_DISP_LO_BASE, 32'h00FF_807F);
        @(negedge ref_clk);
        chk({4'h0, dig3, dig2, dig1, dig0}, {4'h0, 7'h00, 7'h7F, 7'h00, 7'h7F});
        done("outputs");
        swLevel  <= 10'h2A5;
        btnLevel <= 4'hA;
        repeat (3) @(posedge ref_clk);
        rchk(`MMPP_SWITCH_BASE, 32'h2A5, 1'b0);
        apb(1'b1, `MMPP_SWITCH_BASE, 32'hFFFF_FFFF);
        rchk(`MMPP_SWITCH_BASE, 32'h2A5, 1'b0);
        rchk(`MMPP_BTN_BASE, 32'hA, 1'b0);
        apb(1'b1, `MMPP_BTN_BASE + 32'h8, 32'hFFFF_FFFF);
        rchk(`MMPP_BTN_BASE + 32'h8, 32'hF, 1'b0);
        apb(1'b1, `MMPP_BTN_BASE + 32'hC, 32'h5);
        rchk(`MMPP_BTN_BASE + 32'hC, 32'h5, 1'b0);
        done("inputs");
        padA <= 32'hCAFE_BABE;
        padB <= 32'h3C3C_A5A5;
        for (int i = 0; i < 2; i++) begin
            b = i ? `MMPP_EXB_BASE : `MMPP_EXA_BASE;
            apb(1'b1, b + 32'h4, 32'hFFFF_0000);
            apb(1'b1, b, 32'h1234_5678);
            repeat (3) @(posedge ref_clk);
            pad = i ? padB : padA;
            rchk(b, 32'h1234_0000 | (32'h0000_FFFF & pad), 1'b0);
            rchk(b + 32'h4, 32'hFFFF_0000, 1'b0);
            chk(i ? bOe : aOe, 32'hFFFF_0000);
            chk(i ? bOut : aOut, 32'h1234_5678);
            apb(1'b1, b + 32'hC, 32'hF0F0_F0F0);
            rchk(b + 32'hC, 32'hF0F0_F0F0, 1'b0);
            apb(1'b1, b + 32'h8, 32'h0F0F_0F0F);
            rchk(b + 32'h8, 32'h0F0F_0F0F, 1'b0);
        end
        done("expansion");
        rchk(`MMPP_LIGHTS_BASE + 32'h4, 32'h0, 1'b1);
        rchk(`MMPP_LIGHTS_BASE + 32'h2, 32'h0, 1'b1);
        apb(1'b1, 32'hFF20_0010, 32'h0);
        chk({31'h0, err}, 32'h1);
        rchk(`MMPP_LIGHTS_BASE, 32'h155, 1'b0);
        done("unmapped");
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        rchk(`MMPP_LIGHTS_BASE, 32'h0, 1'b0);
        chk(aOe, 32'h0);
        done("second reset");
        wrap_up();
    end
endmodule

// file: testbench/mmpp_board_model.sv
// Board side of the parallel ports: switches, buttons and header pins.
// Assumes the bench sets the levels the board would present.
`timescale 1ns/1ps
module mmpp_board_model (
    input  wire logic  [9:0] swLevel,
    input  wire logic  [3:0] btnLevel,
    input  wire logic [31:0] padA,
    input  wire logic [31:0] padB,
    input  wire logic [31:0] outA,
    input  wire logic [31:0] oeA,
    input  wire logic [31:0] outB,
    input  wire logic [31:0] oeB,
    output logic       [9:0] slideSwitches,
    output logic       [3:0] pushbuttons,
    output logic      [31:0] pinA,
    output logic      [31:0] pinB
);
    // Each header pin carries the block's level where it drives, else the board's.
    assign slideSwitches = swLevel;
    assign pushbuttons   = btnLevel;
    assign pinA          = (oeA & outA) | (~oeA & padA);
    assign pinB          = (oeB & outB) | (~oeB & padB);
endmodule

// file: testbench/mmpp_ports_checker.sv
// Concurrent checks on the parallel port block's APB side and pin outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`include "mmpp_consts.svh"
module mmpp_ports_checker (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic  [9:0] redLights,
    input wire logic  [6:0] displayDigit0,
    input wire logic  [6:0] displayDigit3,
    input wire logic  [6:0] displayDigit4,
    input wire logic  [6:0] displayDigit5,
    input wire logic [31:0] expansionHeaderAOe,
    input wire logic [31:0] expansionHeaderBOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------------
    // Access sequences
    // ------------------------------------------------------------------
    sequence s_wr(logic [31:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence s_rd(logic [31:0] a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence
    AST_LIGHT_WR: assert property (s_wr(`MMPP_LIGHTS_BASE) |=>
        redLights == $past(pwdata[9:0])) else $error("light pins miss write");
    AST_LIGHT_RD: assert property (s_rd(`MMPP_LIGHTS_BASE) |->
        prdata == {22'h0, redLights}) else $error("light readback wrong");
    AST_DISP_LO: assert property (s_wr(`MMPP_DISP_LO_BASE) |=>
        displayDigit0 == $past(pwdata[6:0]) && displayDigit3 == $past(pwdata[30:24]))
        else $error("low digits wrong");
    AST_DISP_HI: assert property (s_wr(`MMPP_DISP_HI_BASE) |=>
        displayDigit4 == $past(pwdata[6:0]) && displayDigit5 == $past(pwdata[14:8]))
        else $error("high digits wrong");
    AST_EXA_DIR: assert property (s_wr(`MMPP_EXA_BASE + 32'h4) |=>
        expansionHeaderAOe == $past(pwdata)) else $error("direction not applied");
    AST_EXB_OUT: assert property (s_wr(`MMPP_EXB_BASE) |=>
        expansionHeaderBOut == $past(pwdata)) else $error("header data not applied");
    AST_SW_UPPER: assert property (s_rd(`MMPP_SWITCH_BASE) |->
        prdata[31:10] == 22'h0 && !pslverr) else $error("switch read wrong");
    AST_UNMAPPED: assert property (s_rd(`MMPP_LIGHTS_BASE + 32'h4) |->
        pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    AST_RESET: assert property ($rose(nrst) |->
        redLights == 10'h0 && expansionHeaderAOe == 32'h0) else $error("reset value wrong");
    AST_LIGHT_HOLD: assert property (!(psel && penable && pwrite) |=>
        $stable(redLights)) else $error("lights moved without write");
endmodule

bind mmpp_ports mmpp_ports_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .redLights(redLights), .displayDigit0(displayDigit0),
    .displayDigit3(displayDigit3), .displayDigit4(displayDigit4),
    .displayDigit5(displayDigit5), .expansionHeaderAOe(expansionHeaderAOe),
    .expansionHeaderBOut(expansionHeaderBOut));
